// ===== logic/color_sensor_config_threshold_regs.sv
/*
 * Command-addressed register bank: both configuration bytes, green
 * interrupt limits, red result, and the green persistence filter.
 * Assumes the I2C host controller and the measurement core run on
 * i_core_clk, so no synchroniser stands on their signals.
 */
`timescale 1ns/1ps
module color_sensor_config_threshold_regs
    import color_sensor_regs_pkg::*;
#(
    parameter int COUNT_WIDTH = 16
) (
    input wire logic i_core_clk,                     // Core clock, 40 MHz
    input wire logic i_rst_b,                        // Synchronous reset, low
    input wire cmd_req_type i_cmd,                   // Command read/write
    output logic [7:0] o_rd_data,                    // Read data
    output logic o_rd_valid,                         // Read data valid pulse
    input wire logic i_meas_done,                    // Integration complete
    input wire logic [COUNT_WIDTH-1:0] i_red_count,  // New red count
    input wire logic [COUNT_WIDTH-1:0] i_green_count, // New green count
    output logic o_sensor_enable,                    // Both halves released
    output logic o_photodiode_half_select,           // Half photodiode
    output logic [1:0] o_color_gain_select,          // Gain code
    output logic o_calibration_enable,               // Calibration on
    output logic o_green_int_enable,                 // Green interrupt on
    output logic o_green_high_event,                 // High crossing pulse
    output logic o_green_low_event                   // Low crossing pulse
);

    ////////////////////////////////////////////////////////////////////////
    // Storage
    logic [7:0] config_first;
    config_second_type sensor_config_second;
    logic [7:0] green_high_limit_low;
    logic [7:0] green_high_limit_high;
    logic [7:0] green_low_limit_low;
    logic [7:0] green_low_limit_high;
    logic [COUNT_WIDTH-1:0] red_result;
    logic [7:0] red_high_snapshot;
    logic [COUNT_WIDTH-1:0] green_result;
    logic green_sample;
    logic [1:0] filter_event;
    logic [7:0] next_rd_data;
    logic wr_hit;
    logic rd_hit;

    assign wr_hit = i_cmd.wr;
    assign rd_hit = i_cmd.rd;

    ////////////////////////////////////////////////////////////////////////
    // First configuration byte; only the shutdown and interrupt
    // enable bits steer logic here, the rest is held for readback
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            config_first <= CONFIG_FIRST_RESET;
        end else if (wr_hit && i_cmd.addr == CMD_CONFIG_FIRST) begin
            config_first <= i_cmd.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Second configuration byte
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            sensor_config_second <= config_second_type'(CONFIG_SECOND_RESET);
        end else if (wr_hit && i_cmd.addr == CMD_CONFIG_SECOND) begin
            sensor_config_second.shutdown_half_b <= i_cmd.data[SHUTDOWN_HALF_B_BIT];
            sensor_config_second.photodiode_half_select <= i_cmd.data[PHOTODIODE_HALF_BIT];
            // Stored as written; the host is expected to keep it zero
            sensor_config_second.reserved <= i_cmd.data[RESERVED_BIT];
            sensor_config_second.color_gain_select <= i_cmd.data[GAIN_MSB:GAIN_LSB];
            sensor_config_second.crossing_persistence <= i_cmd.data[PERSIST_MSB:PERSIST_LSB];
            sensor_config_second.calibration_enable <= i_cmd.data[CALIBRATION_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Green high limit bytes
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            green_high_limit_low <= LIMIT_RESET[7:0];
            green_high_limit_high <= LIMIT_RESET[15:8];
        end else if (wr_hit) begin
            if (i_cmd.addr == CMD_GREEN_HIGH_LIMIT_LOW) begin
                green_high_limit_low <= i_cmd.data;
            end
            if (i_cmd.addr == CMD_GREEN_HIGH_LIMIT_HIGH) begin
                green_high_limit_high <= i_cmd.data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Green low limit bytes
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            green_low_limit_low <= LIMIT_RESET[7:0];
            green_low_limit_high <= LIMIT_RESET[15:8];
        end else if (wr_hit) begin
            if (i_cmd.addr == CMD_GREEN_LOW_LIMIT_LOW) begin
                green_low_limit_low <= i_cmd.data;
            end
            if (i_cmd.addr == CMD_GREEN_LOW_LIMIT_HIGH) begin
                green_low_limit_high <= i_cmd.data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Red result, loaded only at the end of an integration
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            red_result <= RESULT_RESET;
        end else if (i_meas_done) begin
            red_result <= i_red_count;
        end
    end

    // Reading the low byte freezes the high byte of the same result,
    // so a low-then-high read never mixes two measurements
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            red_high_snapshot <= RESULT_RESET[15:8];
        end else if (rd_hit && i_cmd.addr == CMD_RED_RESULT_LOW) begin
            red_high_snapshot <= red_result[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Green sample staged so the filter sees the count with its pulse
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            green_result <= RESULT_RESET;
            green_sample <= 1'b0;
        end else begin
            green_sample <= i_meas_done;
            if (i_meas_done) begin
                green_result <= i_green_count;
            end
        end
    end

    // Persistence filter on the green result
    green_crossing_filter #(
        .COUNT_WIDTH(COUNT_WIDTH)
    ) u_green_filter (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_sample(green_sample),
        .i_enable(config_first[GREEN_INT_ENABLE_BIT]),
        .i_count(green_result),
        .i_high({green_high_limit_high, green_high_limit_low}),
        .i_low({green_low_limit_high, green_low_limit_low}),
        .i_persist(sensor_config_second.crossing_persistence),
        .o_event(filter_event)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read multiplexer; unmapped commands read as zero
    always_comb begin
        next_rd_data = READ_UNMAPPED;
        case (i_cmd.addr)
            CMD_CONFIG_FIRST: next_rd_data = config_first;
            CMD_CONFIG_SECOND: next_rd_data = sensor_config_second;
            CMD_GREEN_HIGH_LIMIT_LOW: next_rd_data = green_high_limit_low;
            CMD_GREEN_HIGH_LIMIT_HIGH: next_rd_data = green_high_limit_high;
            CMD_GREEN_LOW_LIMIT_LOW: next_rd_data = green_low_limit_low;
            CMD_GREEN_LOW_LIMIT_HIGH: next_rd_data = green_low_limit_high;
            CMD_RED_RESULT_LOW: next_rd_data = red_result[7:0];
            CMD_RED_RESULT_HIGH: next_rd_data = red_high_snapshot;
            default: next_rd_data = READ_UNMAPPED;
        endcase
    end

    // Read answer one cycle after the request
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_rd_data <= READ_UNMAPPED;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= rd_hit;
            if (rd_hit) begin
                o_rd_data <= next_rd_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control outputs, registered from the stored configuration.
    // The sensor runs only once both shutdown halves are clear.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_sensor_enable <= 1'b0;
            o_photodiode_half_select <= 1'b0;
            o_color_gain_select <= GAIN_X1;
            o_calibration_enable <= 1'b0;
            o_green_int_enable <= 1'b0;
        end else begin
            o_sensor_enable <= !(config_first[SHUTDOWN_HALF_A_BIT]
                | sensor_config_second.shutdown_half_b);
            o_photodiode_half_select <= sensor_config_second.photodiode_half_select;
            o_color_gain_select <= sensor_config_second.color_gain_select;
            o_calibration_enable <= sensor_config_second.calibration_enable;
            o_green_int_enable <= config_first[GREEN_INT_ENABLE_BIT];
        end
    end

    // Crossing events out of the filter
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_green_high_event <= 1'b0;
            o_green_low_event <= 1'b0;
        end else begin
            o_green_high_event <= filter_event[1];
            o_green_low_event <= filter_event[0];
        end
    end

endmodule

// ===== logic/color_sensor_regs_pkg.sv
/*
 * Constants, field layouts and carrier types for the color sensor
 * configuration, threshold and red result register bank.
 * Assumes one core clock; all parties sit on that clock.
 */
package color_sensor_regs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Command codes
    localparam logic [7:0] CMD_CONFIG_FIRST = 8'h00;
    localparam logic [7:0] CMD_CONFIG_SECOND = 8'h01;
    localparam logic [7:0] CMD_GREEN_HIGH_LIMIT_LOW = 8'h04;
    localparam logic [7:0] CMD_GREEN_HIGH_LIMIT_HIGH = 8'h05;
    localparam logic [7:0] CMD_GREEN_LOW_LIMIT_LOW = 8'h06;
    localparam logic [7:0] CMD_GREEN_LOW_LIMIT_HIGH = 8'h07;
    localparam logic [7:0] CMD_RED_RESULT_LOW = 8'h10;
    localparam logic [7:0] CMD_RED_RESULT_HIGH = 8'h11;

    ////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [7:0] CONFIG_FIRST_RESET = 8'h01;
    localparam logic [7:0] CONFIG_SECOND_RESET = 8'h80;
    localparam logic [15:0] LIMIT_RESET = 16'h0000;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    localparam logic [3:0] CROSSING_COUNT_RESET = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // Field positions, first configuration byte
    localparam int SHUTDOWN_HALF_A_BIT = 0;
    localparam int GREEN_INT_ENABLE_BIT = 1;

    // Field positions, second configuration byte
    localparam int SHUTDOWN_HALF_B_BIT = 7;
    localparam int PHOTODIODE_HALF_BIT = 6;
    localparam int RESERVED_BIT = 5;
    localparam int GAIN_MSB = 4;
    localparam int GAIN_LSB = 3;
    localparam int PERSIST_MSB = 2;
    localparam int PERSIST_LSB = 1;
    localparam int CALIBRATION_BIT = 0;

    ////////////////////////////////////////////////////////////////////////
    // Gain codes
    localparam logic [1:0] GAIN_X1 = 2'h0;
    localparam logic [1:0] GAIN_X2 = 2'h1;
    localparam logic [1:0] GAIN_X0_66 = 2'h2;
    localparam logic [1:0] GAIN_X0_5 = 2'h3;

    // Crossings needed per persistence code
    localparam logic [3:0] PERSIST_COUNT_1 = 4'h1;
    localparam logic [3:0] PERSIST_COUNT_2 = 4'h2;
    localparam logic [3:0] PERSIST_COUNT_4 = 4'h4;
    localparam logic [3:0] PERSIST_COUNT_8 = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // Carrier types
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } cmd_req_type;

    typedef struct packed {
        logic shutdown_half_b;
        logic photodiode_half_select;
        logic reserved;
        logic [1:0] color_gain_select;
        logic [1:0] crossing_persistence;
        logic calibration_enable;
    } config_second_type;

    // Decode a persistence code to a crossing count
    function automatic logic [3:0] persist_needed(input logic [1:0] code);
        case (code)
            2'h0: persist_needed = PERSIST_COUNT_1;
            2'h1: persist_needed = PERSIST_COUNT_2;
            2'h2: persist_needed = PERSIST_COUNT_4;
            default: persist_needed = PERSIST_COUNT_8;
        endcase
    endfunction

endpackage

// ===== logic/green_crossing_filter.sv
/*
 * Persistence filter for the green channel limit crossings.
 * Assumes i_sample pulses once per completed measurement, same clock.
 */
`timescale 1ns/1ps
module green_crossing_filter
    import color_sensor_regs_pkg::*;
#(
    parameter int COUNT_WIDTH = 16
) (
    input wire logic i_core_clk,                   // Core clock
    input wire logic i_rst_b,                      // Synchronous reset, low
    input wire logic i_sample,                     // New measurement ready
    input wire logic i_enable,                     // Green interrupt enabled
    input wire logic [COUNT_WIDTH-1:0] i_count,    // Green result
    input wire logic [COUNT_WIDTH-1:0] i_high,     // High limit
    input wire logic [COUNT_WIDTH-1:0] i_low,      // Low limit
    input wire logic [1:0] i_persist,              // Persistence code
    output logic [1:0] o_event                     // Bit 1 high, bit 0 low
);

    logic [1:0] crossing;

    // Direction 1 above the high limit, direction 0 below the low limit
    assign crossing[1] = i_count > i_high;
    assign crossing[0] = i_count < i_low;

    ////////////////////////////////////////////////////////////////////////
    // One successive-crossing counter per direction
    genvar d;
    generate
        for (d = 0; d < 2; d = d + 1) begin : g_dir
            logic [3:0] run_count;
            logic [3:0] next_run;

            assign next_run = run_count + 4'h1;

            // Count successive crossings; raise when the run is long enough
            always_ff @(posedge i_core_clk) begin
                if (!i_rst_b) begin
                    run_count <= CROSSING_COUNT_RESET;
                    o_event[d] <= 1'b0;
                end else if (!i_enable) begin
                    run_count <= CROSSING_COUNT_RESET;
                    o_event[d] <= 1'b0;
                end else if (i_sample && crossing[d]) begin
                    if (next_run >= persist_needed(i_persist)) begin
                        run_count <= CROSSING_COUNT_RESET;
                        o_event[d] <= 1'b1;
                    end else begin
                        run_count <= next_run;
                        o_event[d] <= 1'b0;
                    end
                end else if (i_sample) begin
                    run_count <= CROSSING_COUNT_RESET;
                    o_event[d] <= 1'b0;
                end else begin
                    o_event[d] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule

// ===== test/color_sensor_regs_asserts.sv
/*
 * Port checker for the register bank: read answer, configuration outputs,
 * reset state and event timing. Bound to the top module below.
 */
`timescale 1ns/1ps
module color_sensor_regs_asserts
    import color_sensor_regs_pkg::*;
#(
    parameter int COUNT_WIDTH = 16
) (
    input wire logic i_core_clk,                // Core clock
    input wire logic i_rst_b,                   // Synchronous reset, low
    input wire cmd_req_type i_cmd,              // Command read/write
    input wire logic o_rd_valid,                // Read data valid
    input wire logic i_meas_done,               // Integration complete
    input wire logic o_sensor_enable,           // Both halves released
    input wire logic o_photodiode_half_select,  // Half photodiode
    input wire logic [1:0] o_color_gain_select, // Gain code
    input wire logic o_calibration_enable,      // Calibration on
    input wire logic o_green_high_event,        // High crossing pulse
    input wire logic o_green_low_event          // Low crossing pulse
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    ////////////////////////////////////////////////////////////////////////
    // Write steps on the command port
    sequence seq_cfg2_write;
        i_cmd.wr && i_cmd.addr == CMD_CONFIG_SECOND;
    endsequence
    sequence seq_half_a_clear;
        i_cmd.wr && i_cmd.addr == CMD_CONFIG_FIRST && !i_cmd.data[0];
    endsequence
    sequence seq_half_b_clear;
        i_cmd.wr && i_cmd.addr == CMD_CONFIG_SECOND && !i_cmd.data[7];
    endsequence

    ////////////////////////////////////////////////////////////////////////
    // Read handshake, shutdown and field outputs, event causes
    AST_READ_ANSWER: assert property (i_cmd.rd |=> o_rd_valid)
        else $error("read without valid answer");
    AST_NO_STRAY_VALID: assert property (o_rd_valid |-> $past(i_cmd.rd))
        else $error("valid without read");
    AST_RESET_SHUTDOWN: assert property ($rose(i_rst_b) |-> !o_sensor_enable)
        else $error("sensor on after reset");
    AST_HALF_B_HOLDS_OFF: assert property (seq_cfg2_write and i_cmd.data[7] |-> ##2 !o_sensor_enable)
        else $error("sensor on with half b set");
    AST_BOTH_HALVES_START: assert property (seq_half_a_clear ##1 seq_half_b_clear |-> ##2 o_sensor_enable)
        else $error("sensor not started");
    AST_PD_FOLLOWS: assert property (seq_cfg2_write |-> ##2 o_photodiode_half_select == $past(i_cmd.data[6], 2))
        else $error("photodiode select wrong");
    AST_GAIN_FOLLOWS: assert property (seq_cfg2_write |-> ##2 o_color_gain_select == $past(i_cmd.data[4:3], 2))
        else $error("gain select wrong");
    AST_CAL_FOLLOWS: assert property (seq_cfg2_write |-> ##2 o_calibration_enable == $past(i_cmd.data[0], 2))
        else $error("calibration enable wrong");
    AST_HIGH_EVENT_CAUSE: assert property (o_green_high_event |-> $past(i_meas_done, 3))
        else $error("high event without measurement");
    AST_LOW_EVENT_CAUSE: assert property (o_green_low_event |-> $past(i_meas_done, 3))
        else $error("low event without measurement");
endmodule

bind color_sensor_config_threshold_regs color_sensor_regs_asserts #(.COUNT_WIDTH(COUNT_WIDTH)) u_asserts (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_cmd(i_cmd), .o_rd_valid(o_rd_valid),
    .i_meas_done(i_meas_done), .o_sensor_enable(o_sensor_enable),
    .o_photodiode_half_select(o_photodiode_half_select),
    .o_color_gain_select(o_color_gain_select), .o_calibration_enable(o_calibration_enable),
    .o_green_high_event(o_green_high_event), .o_green_low_event(o_green_low_event));

// ===== test/host_cmd_model.sv
/*
 * Host side model: issues one command byte per request on the command port.
 * Assumes the bench calls its tasks; changes drive only at falling edges.
 */
`timescale 1ns/1ps
module host_cmd_model
    import color_sensor_regs_pkg::*;
(
    input wire logic i_core_clk,      // Core clock
    input wire logic [7:0] i_rd_data, // Read data from the device
    input wire logic i_rd_valid,      // Read data valid
    output cmd_req_type o_cmd         // Command toward the device
);
    ////////////////////////////////////////////////////////////////////////
    // Idle bus until the first request
    initial o_cmd = '0;

    // One write; the reserved bit of the second byte is always sent as zero
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        o_cmd = '{wr: 1'b1, rd: 1'b0, addr: a, data: (a == CMD_CONFIG_SECOND) ? (d & 8'hDF) : d};
        @(negedge i_core_clk);
        o_cmd.wr = 1'b0;
    endtask

    // One read; answer is taken one cycle after the request edge
    task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge i_core_clk);
        o_cmd = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        @(negedge i_core_clk);
        d = i_rd_data;
        v = i_rd_valid;
        o_cmd.rd = 1'b0;
    endtask

    // Start: both shutdown halves cleared back to back, calibration set
    task automatic start_sensor(input logic [7:0] first, input logic [7:0] second);
        @(negedge i_core_clk);
        o_cmd = '{wr: 1'b1, rd: 1'b0, addr: CMD_CONFIG_FIRST, data: first & 8'hFE};
        @(negedge i_core_clk);
        o_cmd = '{wr: 1'b1, rd: 1'b0, addr: CMD_CONFIG_SECOND, data: (second | 8'h01) & 8'h5F};
        @(negedge i_core_clk);
        o_cmd.wr = 1'b0;
    endtask
endmodule

// ===== test/test_color_sensor_config_threshold_regs.sv
/*
 * Self-checking bench for the register bank: host model on the command
 * port, bench drives the measurement side. Assumes one 40 MHz clock.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module test_color_sensor_config_threshold_regs;
    import color_sensor_regs_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    cmd_req_type i_cmd;
    logic [7:0] o_rd_data;
    logic o_rd_valid, i_meas_done, o_sensor_enable, o_photodiode_half_select;
    logic o_calibration_enable, o_green_int_enable, o_green_high_event, o_green_low_event;
    logic [1:0] o_color_gain_select, ev;
    logic [15:0] i_red_count, i_green_count;
    logic [7:0] cfg;
    logic [7:0] lim [4] = '{8'h34, 8'h12, 8'h00, 8'h01};
    logic [15:0] run_g [4] = '{16'h1235, 16'h1234, 16'h1235, 16'h1235};
    int mismatches = 0;
    int n_tests = 0;

    ////////////////////////////////////////////////////////////////////////
    // Device and host model
    color_sensor_config_threshold_regs #(.COUNT_WIDTH(16)) dut (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_cmd(i_cmd), .o_rd_data(o_rd_data),
        .o_rd_valid(o_rd_valid), .i_meas_done(i_meas_done), .i_red_count(i_red_count),
        .i_green_count(i_green_count), .o_sensor_enable(o_sensor_enable),
        .o_photodiode_half_select(o_photodiode_half_select),
        .o_color_gain_select(o_color_gain_select), .o_calibration_enable(o_calibration_enable),
        .o_green_int_enable(o_green_int_enable), .o_green_high_event(o_green_high_event),
        .o_green_low_event(o_green_low_event));
    host_cmd_model host (.i_core_clk(i_core_clk), .i_rd_data(o_rd_data),
        .i_rd_valid(o_rd_valid), .o_cmd(i_cmd));

    // 25 ns clock
    initial forever #12.5 i_core_clk = ~i_core_clk;

    ////////////////////////////////////////////////////////////////////////
    // Verdict and run end
    task automatic end_of_test();
        if (mismatches == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Read and compare one byte
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        host.read_byte(a, d, v);
        `CHK("rd_valid", 1'b1, v)
        `CHK("rd_data", e, d)
    endtask

    // One measurement; events are sampled in the third cycle after it
    task automatic sample(input logic [15:0] r, input logic [15:0] g, output logic [1:0] e);
        logic bad;
        bad = 1'b0;
        e = 2'b00;
        @(negedge i_core_clk);
        i_meas_done = 1'b1;
        i_red_count = r;
        i_green_count = g;
        for (int k = 1; k <= 5; k++) begin
            @(negedge i_core_clk);
            i_meas_done = 1'b0;
            if (k == 3) e = {o_green_high_event, o_green_low_event};
            else if (o_green_high_event !== 1'b0 || o_green_low_event !== 1'b0) bad = 1'b1;
        end
        `CHK("event_timing", 1'b0, bad)
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        i_meas_done = 1'b0;
        i_red_count = 16'h0000;
        i_green_count = 16'h0000;
        repeat (10) @(negedge i_core_clk);
        i_rst_b = 1'b1;
        rd_chk(CMD_CONFIG_FIRST, CONFIG_FIRST_RESET);
        rd_chk(CMD_CONFIG_SECOND, CONFIG_SECOND_RESET);
        rd_chk(8'h02, READ_UNMAPPED);
        `CHK("sensor_enable", 1'b0, o_sensor_enable)
        // Half b set keeps the sensor off; both halves cleared back to back start it
        host.write_byte(CMD_CONFIG_SECOND, 8'h80);
        repeat (2) @(negedge i_core_clk);
        `CHK("sensor_enable", 1'b0, o_sensor_enable)
        host.start_sensor(8'h02, 8'h00);
        repeat (2) @(negedge i_core_clk);
        `CHK("sensor_enable", 1'b1, o_sensor_enable)
        `CHK("calibration", 1'b1, o_calibration_enable)
        `CHK("int_enable", 1'b1, o_green_int_enable)
        host.write_byte(CMD_CONFIG_SECOND, 8'h81);
        repeat (2) @(negedge i_core_clk);
        `CHK("sensor_enable", 1'b0, o_sensor_enable)
        host.start_sensor(8'h02, 8'h00);
        for (int c = 0; c < 4; c++) begin
            cfg = {1'b0, c[0], 1'b0, c[1:0], 2'b00, ~c[0]};
            host.write_byte(CMD_CONFIG_SECOND, cfg);
            repeat (2) @(negedge i_core_clk);
            `CHK("gain", c[1:0], o_color_gain_select)
            `CHK("pd_half", c[0], o_photodiode_half_select)
            `CHK("calibration", ~c[0], o_calibration_enable)
            rd_chk(CMD_CONFIG_SECOND, cfg);
        end
        for (int i = 0; i < 4; i++) host.write_byte(8'(CMD_GREEN_HIGH_LIMIT_LOW + i), lim[i]);
        for (int i = 0; i < 4; i++) rd_chk(8'(CMD_GREEN_HIGH_LIMIT_LOW + i), lim[i]);
        sample(16'hBEEF, 16'h1000, ev);
        `CHK("no_event", 2'b00, ev)
        i_red_count = 16'h5555;
        host.write_byte(CMD_RED_RESULT_LOW, 8'hAA);
        rd_chk(CMD_RED_RESULT_LOW, 8'hEF);
        rd_chk(CMD_RED_RESULT_HIGH, 8'hBE);
        for (int p = 0; p < 4; p++) begin
            host.write_byte(CMD_CONFIG_SECOND, {5'b00000, p[1:0], 1'b1});
            repeat (2) @(negedge i_core_clk);
            for (int s = 1; s <= (1 << p); s++) begin
                sample(16'h0000, 16'h1235, ev);
                `CHK("high_event", (s == (1 << p)) ? 2'b10 : 2'b00, ev)
            end
        end
        host.write_byte(CMD_CONFIG_SECOND, 8'h03);
        for (int i = 0; i < 4; i++) begin
            sample(16'h0000, run_g[i], ev);
            `CHK("run_event", (i == 3) ? 2'b10 : 2'b00, ev)
        end
        host.write_byte(CMD_CONFIG_SECOND, 8'h01);
        sample(16'h0000, 16'h0100, ev);
        `CHK("low_edge", 2'b00, ev)
        sample(16'h0000, 16'h00FF, ev);
        `CHK("low_event", 2'b01, ev)
        host.write_byte(CMD_CONFIG_FIRST, 8'h00);
        repeat (2) @(negedge i_core_clk);
        `CHK("int_enable", 1'b0, o_green_int_enable)
        sample(16'h0000, 16'h00FF, ev);
        `CHK("disabled", 2'b00, ev)
        // Mid-run reset brings back shutdown and the reset contents
        i_rst_b = 1'b0;
        repeat (2) @(negedge i_core_clk);
        i_rst_b = 1'b1;
        rd_chk(CMD_CONFIG_FIRST, CONFIG_FIRST_RESET);
        rd_chk(CMD_CONFIG_SECOND, CONFIG_SECOND_RESET);
        rd_chk(CMD_GREEN_HIGH_LIMIT_HIGH, LIMIT_RESET[15:8]);
        rd_chk(CMD_RED_RESULT_LOW, RESULT_RESET[7:0]);
        `CHK("sensor_enable", 1'b0, o_sensor_enable)
        end_of_test();
    end

    // Watchdog well beyond the expected run of about 250 cycles
    initial begin
        repeat (20000) @(posedge i_core_clk);
        mismatches++;
        end_of_test();
    end
endmodule
